// ---- imr_far_end_model.sv ----
/*
  remote terminal model: delivers decoded control cell fields.
  assumes send is called right after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module imr_far_end_model (
  // clock
  input wire logic i_sys_clk,
  // control cell fields
  output logic o_valid,
  output logic [20:0] o_fields
);
  // ****************************************
  // cell delivery
  // ****************************************
  initial begin
    o_valid = 1'b0;
    o_fields = 21'h000000;
  end

  // one-cycle valid; fields inverted after so stale data never matches
  task automatic send(input logic [20:0] f);
    o_valid <= 1'b1;
    o_fields <= f;
    @(posedge i_sys_clk);
    o_valid <= 1'b0;
    o_fields <= ~f;
  endtask : send
endmodule : imr_far_end_model

`default_nettype wire

// ---- imr_link_status.sv ----
/*
  imr_link_status: per-link receive defect, far-end configuration and
  far-end link status registers for 32 links, with interrupt status/mask.
  Assumes defect levels and control cell fields come from logic on
  i_sys_clk; the reference inputs are pins and are synchronised here.
  Assumes read and write strobes never come together; read data is
  valid only in the cycle after the read strobe and reads zero otherwise.
*/
`timescale 1ns/1ps
`default_nettype none

module imr_link_status (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // register port
  input wire logic [10:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rd_data,
  // near-end defect levels, one bit per link
  input wire logic [31:0] i_lif_defect,
  input wire logic [31:0] i_lods_defect,
  input wire logic [31:0] i_rdi_defect,
  input wire logic [31:0] i_phy_defect,
  // receive reference pins, one per link
  input wire logic [31:0] i_rx_reference_input,
  // control cell fields, one-cycle valid
  input wire logic i_icp_valid,
  input wire logic [4:0] i_icp_link,
  input wire logic [1:0] i_icp_frame_len,
  input wire logic i_icp_version,
  input wire logic [4:0] i_icp_link_id,
  input wire logic [2:0] i_icp_fe_tx_state,
  input wire logic [2:0] i_icp_fe_rx_state,
  input wire logic [1:0] i_icp_fe_defect,
  // interrupt
  output logic o_irq
);

  // ****************************************************************
  // address decode
  // ****************************************************************
  // decode is purely combinational so a strobe acts on the edge it is seen

  // kind of register at an address; groups live at 0x400..0x7FF
  function automatic imr_pkg::imr_reg_e reg_kind(input logic [10:0] a);
    imr_pkg::imr_reg_e k;
    k = imr_pkg::IMR_REG_NONE;
    if (a == imr_pkg::IRQ_STATUS_ADDR) begin
      k = imr_pkg::IMR_REG_IRQ_STAT;
    end else if (a == imr_pkg::IRQ_MASK_ADDR) begin
      k = imr_pkg::IMR_REG_IRQ_MASK;
    end else if (a[10]) begin
      if (a[7:3] == imr_pkg::SLOT_DEFECT) begin
        k = imr_pkg::IMR_REG_DEFECT;
      end else if (a[7:3] == imr_pkg::SLOT_FE_CFG) begin
        k = imr_pkg::IMR_REG_FE_CFG;
      end else if (a[7:3] == imr_pkg::SLOT_FE_STATE) begin
        k = imr_pkg::IMR_REG_FE_STATE;
      end
    end
    return k;
  endfunction : reg_kind

  // link number: group from bits 9:8, link in group from bits 2:0
  function automatic logic [4:0] link_of(input logic [10:0] a);
    return {a[9:8], a[2:0]};
  endfunction : link_of

  imr_pkg::imr_reg_e acc_kind;
  logic [4:0] acc_link;
  logic [31:0] link_onehot;
  logic [31:0] defect_rd_sel;
  logic defect_wr;
  logic irq_stat_wr;
  logic irq_mask_wr;

  // one decoder serves both strobes; they never come together
  // a strobe to an unmapped address decodes to none and is ignored
  always_comb begin
    acc_kind = reg_kind(i_addr);
    acc_link = link_of(i_addr);
    link_onehot = 32'h0000_0001 << acc_link;
    defect_rd_sel = (i_rd && acc_kind == imr_pkg::IMR_REG_DEFECT) ? link_onehot : 32'h0000_0000;
    defect_wr = i_wr && acc_kind == imr_pkg::IMR_REG_DEFECT;
    irq_stat_wr = i_wr && acc_kind == imr_pkg::IMR_REG_IRQ_STAT;
    irq_mask_wr = i_wr && acc_kind == imr_pkg::IMR_REG_IRQ_MASK;
  end

  // ****************************************************************
  // near-end defect change tracking
  // ****************************************************************
  // live levels come from logic on this clock, so no synchroniser here

  logic [31:0] lif_prev;
  logic [31:0] lods_prev;
  logic [31:0] rdi_prev;
  logic [31:0] lif_chg;
  logic [31:0] lods_chg;
  logic [31:0] rdi_chg;
  logic [31:0] lif_edge;
  logic [31:0] lods_edge;
  logic [31:0] rdi_edge;

  // a change is any difference from last cycle's level
  always_comb begin
    lif_edge = i_lif_defect ^ lif_prev;
    lods_edge = i_lods_defect ^ lods_prev;
    rdi_edge = i_rdi_defect ^ rdi_prev;
  end

  // previous levels; a defect already active at release counts as a change
  // reset value is the idle level of the defect inputs
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      lif_prev <= imr_pkg::RST_LINKS;
      lods_prev <= imr_pkg::RST_LINKS;
      rdi_prev <= imr_pkg::RST_LINKS;
    end else begin
      lif_prev <= i_lif_defect;
      lods_prev <= i_lods_defect;
      rdi_prev <= i_rdi_defect;
    end
  end

  // sticky change bits: read clears, a same-cycle change wins
  // so a change during the read itself is never lost
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      lif_chg <= imr_pkg::RST_LINKS;
      lods_chg <= imr_pkg::RST_LINKS;
      rdi_chg <= imr_pkg::RST_LINKS;
    end else begin
      lif_chg <= (lif_chg & ~defect_rd_sel) | lif_edge;
      lods_chg <= (lods_chg & ~defect_rd_sel) | lods_edge;
      rdi_chg <= (rdi_chg & ~defect_rd_sel) | rdi_edge;
    end
  end

  // ****************************************************************
  // software-writable physical defect bit
  // ****************************************************************
  // only bit 1 of a write lands; the other defect bits stay read-only

  logic [31:0] phy_force;

  // write sets a forced defect that ors with the live physical defect
  // lets software exercise the defect path with no line fault
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      phy_force <= imr_pkg::RST_LINKS;
    end else if (defect_wr) begin
      phy_force[acc_link] <= i_wr_data[imr_pkg::BIT_PHY];
    end
  end

  // ****************************************************************
  // reference input transition detector
  // ****************************************************************
  // judged on the synchronised copy, so pin to flag adds 2-3 cycles

  logic [31:0] ref_meta;
  logic [31:0] ref_sync;
  logic [31:0] ref_last;
  logic [31:0] ref_edge;
  logic [31:0] ref_bad;
  logic [31:0] ref_err;
  logic [7:0] ref_cnt [32];

  // two-flop synchroniser, then a third flop for edge detection
  // only ref_sync and ref_last feed logic; ref_meta may still be settling
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ref_meta <= imr_pkg::RST_LINKS;
      ref_sync <= imr_pkg::RST_LINKS;
      ref_last <= imr_pkg::RST_LINKS;
    end else begin
      ref_meta <= i_rx_reference_input;
      ref_sync <= ref_meta;
      ref_last <= ref_sync;
    end
  end

  // bad fires once when the idle count reaches its limit
  always_comb begin
    ref_edge = ref_sync ^ ref_last;
    for (int i = 0; i < 32; i++) begin
      ref_bad[i] = !ref_edge[i] && ref_cnt[i] == imr_pkg::REF_CNT_LIM - 8'h01;
    end
  end

  // idle counters saturate at the limit so a dead input flags only once
  // limitation: a pin toggling slower than the limit also counts as bad
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 32; i++) begin
        ref_cnt[i] <= imr_pkg::RST_REF_CNT;
      end
    end else begin
      for (int i = 0; i < 32; i++) begin
        if (ref_edge[i]) begin
          ref_cnt[i] <= 8'h00;
        end else if (ref_cnt[i] != imr_pkg::REF_CNT_LIM) begin
          ref_cnt[i] <= ref_cnt[i] + 8'h01;
        end
      end
    end
  end

  // error flag: set by detector, cleared by reading the defects register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ref_err <= imr_pkg::RST_LINKS;
    end else begin
      ref_err <= (ref_err & ~defect_rd_sel) | ref_bad;
    end
  end

  // ****************************************************************
  // far-end registers from arriving control cells
  // ****************************************************************
  // cells are taken on the valid pulse; the link number picks the entry

  logic [7:0] fe_cfg [32];
  logic [7:0] fe_state [32];

  // whole register replaced on each valid cell for that link
  // a cell for one link never disturbs the others
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 32; i++) begin
        fe_cfg[i] <= imr_pkg::RST_REG;
        fe_state[i] <= imr_pkg::RST_REG;
      end
    end else if (i_icp_valid) begin
      fe_cfg[i_icp_link][imr_pkg::FL_LSB +: 2] <= i_icp_frame_len;
      fe_cfg[i_icp_link][imr_pkg::VER_LSB] <= i_icp_version;
      fe_cfg[i_icp_link][imr_pkg::LID_LSB +: 5] <= i_icp_link_id;
      fe_state[i_icp_link][imr_pkg::FE_TX_LSB +: 3] <= i_icp_fe_tx_state;
      fe_state[i_icp_link][imr_pkg::FE_RX_LSB +: 3] <= i_icp_fe_rx_state;
      fe_state[i_icp_link][imr_pkg::FE_DEF_LSB +: 2] <= i_icp_fe_defect;
    end
  end

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  // one summary bit per kind of event; software polls links for detail

  logic [4:0] irq_stat;
  logic [4:0] irq_mask;
  logic [4:0] irq_event;
  logic [4:0] irq_w1c;
  logic [4:0] next_irq_stat;
  logic [4:0] next_irq_mask;

  // events from any link; write-one-to-clear loses to a same-cycle event
  always_comb begin
    irq_event = '0;
    irq_event[imr_pkg::IRQ_LIF] = |lif_edge;
    irq_event[imr_pkg::IRQ_LODS] = |lods_edge;
    irq_event[imr_pkg::IRQ_RDI] = |rdi_edge;
    irq_event[imr_pkg::IRQ_REF] = |ref_bad;
    irq_event[imr_pkg::IRQ_FE] = i_icp_valid;
    irq_w1c = irq_stat_wr ? i_wr_data[4:0] : 5'h00;
    next_irq_stat = (irq_stat & ~irq_w1c) | irq_event;
    next_irq_mask = irq_mask_wr ? i_wr_data[4:0] : irq_mask;
  end

  // sticky status
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_stat <= imr_pkg::RST_IRQ;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  // mask: a one lets the status bit through
  // a mask write reaches the pin at the same edge as the register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_mask <= imr_pkg::RST_IRQ;
    end else begin
      irq_mask <= next_irq_mask;
    end
  end

  // built from next values so the pin follows status with no lag
  // still a flop, so decode glitches never reach the pin
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= imr_pkg::RST_IRQ_PIN;
    end else begin
      o_irq <= |(next_irq_stat & next_irq_mask);
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  // reads have no side effect except clearing the change and error bits

  logic [7:0] next_rd_data;

  // live bits come straight from inputs, change bits from the sticky flops
  // live bits therefore show the level of the read strobe's cycle
  always_comb begin
    next_rd_data = 8'h00;
    case (acc_kind)
      imr_pkg::IMR_REG_DEFECT: begin
        next_rd_data[imr_pkg::BIT_LIF_CHG] = lif_chg[acc_link];
        next_rd_data[imr_pkg::BIT_LIF] = i_lif_defect[acc_link];
        next_rd_data[imr_pkg::BIT_LODS_CHG] = lods_chg[acc_link];
        next_rd_data[imr_pkg::BIT_LODS] = i_lods_defect[acc_link];
        next_rd_data[imr_pkg::BIT_RDI_CHG] = rdi_chg[acc_link];
        next_rd_data[imr_pkg::BIT_RDI] = i_rdi_defect[acc_link];
        next_rd_data[imr_pkg::BIT_PHY] = i_phy_defect[acc_link] | phy_force[acc_link];
        next_rd_data[imr_pkg::BIT_REF_ERR] = ref_err[acc_link];
      end
      imr_pkg::IMR_REG_FE_CFG: begin
        next_rd_data = fe_cfg[acc_link];
      end
      imr_pkg::IMR_REG_FE_STATE: begin
        next_rd_data = fe_state[acc_link];
      end
      imr_pkg::IMR_REG_IRQ_STAT: begin
        next_rd_data = {3'h0, irq_stat};
      end
      imr_pkg::IMR_REG_IRQ_MASK: begin
        next_rd_data = {3'h0, irq_mask};
      end
      default: begin
        next_rd_data = 8'h00; // unmapped reads as zero
      end
    endcase
  end

  // data valid only in the cycle after the read strobe, zero otherwise
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= imr_pkg::RST_REG;
    end else if (i_rd) begin
      o_rd_data <= next_rd_data;
    end else begin
      o_rd_data <= imr_pkg::RST_REG;
    end
  end

endmodule : imr_link_status

`default_nettype wire

// ---- imr_link_status_asserts.sv ----
/*
  checker for the link status bank, bound to its top module.
  assumes one clock and async active-high reset; watches link 0 only.
*/
`timescale 1ns/1ps
`default_nettype none

module imr_link_status_chk (
  // clock, reset and register port
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [10:0] i_addr,
  input wire logic i_rd,
  input wire logic [7:0] o_rd_data,
  // near-end levels
  input wire logic [31:0] i_lif_defect,
  input wire logic [31:0] i_lods_defect,
  input wire logic [31:0] i_rdi_defect,
  input wire logic [31:0] i_phy_defect,
  // control cell fields
  input wire logic i_icp_valid,
  input wire logic [4:0] i_icp_link,
  input wire logic [1:0] i_icp_frame_len,
  input wire logic i_icp_version,
  input wire logic [4:0] i_icp_link_id,
  input wire logic [2:0] i_icp_fe_tx_state,
  input wire logic [2:0] i_icp_fe_rx_state,
  input wire logic [1:0] i_icp_fe_defect
);
  // ****************************************
  // reads of link 0 registers
  // ****************************************
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  wire rd_def = i_rd && i_addr == 11'h490;
  wire rd_cfg = i_rd && i_addr == 11'h498;
  wire rd_st = i_rd && i_addr == 11'h4A0;

  property p_rd_idle;
    !$past(i_rd) |-> o_rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_lif;
    rd_def |=> o_rd_data[6] == $past(i_lif_defect[0]);
  endproperty
  a_lif: assert property (p_lif) else $error("frame loss live bit");
  property p_lods;
    rd_def |=> o_rd_data[4] == $past(i_lods_defect[0]);
  endproperty
  a_lods: assert property (p_lods) else $error("delay sync live bit");
  property p_rdi;
    rd_def |=> o_rd_data[2] == $past(i_rdi_defect[0]);
  endproperty
  a_rdi: assert property (p_rdi) else $error("remote defect live bit");
  property p_phy;
    rd_def && i_phy_defect[0] |=> o_rd_data[1];
  endproperty
  a_phy: assert property (p_phy) else $error("phy bit low");
  property p_lif_chg;
    $changed(i_lif_defect[0]) ##1 rd_def |=> o_rd_data[7];
  endproperty
  a_lif_chg: assert property (p_lif_chg) else $error("frame loss change missed");
  property p_rd_clr;
    (rd_def && $stable(i_lif_defect[0])) ##1 rd_def |=> !o_rd_data[7];
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("change bit not cleared");
  property p_cfg;
    (i_icp_valid && i_icp_link == 5'h00) ##1 (rd_cfg && !i_icp_valid) |=>
      o_rd_data == {$past(i_icp_frame_len, 2), $past(i_icp_version, 2), $past(i_icp_link_id, 2)};
  endproperty
  a_cfg: assert property (p_cfg) else $error("far-end config mismatch");
  property p_st;
    (i_icp_valid && i_icp_link == 5'h00) ##1 (rd_st && !i_icp_valid) |=>
      o_rd_data == {$past(i_icp_fe_tx_state, 2), $past(i_icp_fe_rx_state, 2), $past(i_icp_fe_defect, 2)};
  endproperty
  a_st: assert property (p_st) else $error("far-end status mismatch");
endmodule : imr_link_status_chk

bind imr_link_status imr_link_status_chk u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_rd(i_rd), .o_rd_data(o_rd_data), .i_lif_defect(i_lif_defect), .i_lods_defect(i_lods_defect),
  .i_rdi_defect(i_rdi_defect), .i_phy_defect(i_phy_defect), .i_icp_valid(i_icp_valid),
  .i_icp_link(i_icp_link), .i_icp_frame_len(i_icp_frame_len), .i_icp_version(i_icp_version),
  .i_icp_link_id(i_icp_link_id), .i_icp_fe_tx_state(i_icp_fe_tx_state),
  .i_icp_fe_rx_state(i_icp_fe_rx_state), .i_icp_fe_defect(i_icp_fe_defect));

`default_nettype wire

// ---- imr_link_status_tb.sv ----
/*
  self-checking bench for the link status bank: register reads and writes,
  defect levels, reference pins and far-end cells. assumes the checker bind.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ****************************************
  // stimulus and observation
  // ****************************************
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [10:0] i_addr = 11'h000;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rd_data;
  logic o_irq;
  logic [31:0] lif = 32'h0, lods = 32'h0, rdi = 32'h0, phy = 32'h0;
  logic [31:0] ref_in = 32'h0, ref_hold = 32'h0;
  logic icp_valid;
  logic [20:0] icp;
  int errors = 0;
  int checked = 0;

  // 125 MHz clock; reference pins toggle unless held
  always #4 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) ref_in <= ref_in ^ ~ref_hold;

  imr_link_status DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_lif_defect(lif), .i_lods_defect(lods),
    .i_rdi_defect(rdi), .i_phy_defect(phy), .i_rx_reference_input(ref_in), .i_icp_valid(icp_valid),
    .i_icp_link(icp[20:16]), .i_icp_frame_len(icp[15:14]), .i_icp_version(icp[13]),
    .i_icp_link_id(icp[12:8]), .i_icp_fe_tx_state(icp[7:5]), .i_icp_fe_rx_state(icp[4:2]),
    .i_icp_fe_defect(icp[1:0]), .o_irq(o_irq));
  imr_far_end_model u_far (.i_sys_clk(i_sys_clk), .o_valid(icp_valid), .o_fields(icp));

  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : check

  function automatic logic [10:0] addr(input logic [10:0] base, input int k);
    return base + 11'(k / 8) * 11'h100 + 11'(k % 8);
  endfunction : addr

  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    @(posedge i_sys_clk);
  endtask : wr

  // data sampled at the edge that ends its only valid cycle
  task automatic rd2(input logic [10:0] a, input bit two, output logic [7:0] d1, output logic [7:0] d2);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    if (!two) i_rd <= 1'b0;
    @(posedge i_sys_clk);
    d1 = o_rd_data;
    i_rd <= 1'b0;
    @(posedge i_sys_clk);
    d2 = o_rd_data;
  endtask : rd2

  task automatic rdc(input logic [10:0] a, input logic [7:0] e);
    logic [7:0] d1, d2;
    rd2(a, 1'b0, d1, d2);
    check($sformatf("read %h", a), d1, e);
  endtask : rdc

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_defects();
    int k;
    logic [7:0] d1, d2;
    for (int j = 0; j < 4; j++) begin
      k = j * 10 + j / 3;
      lif[k] <= 1'b1;
      lods[k] <= 1'b1;
      rdi[k] <= 1'b1;
      @(posedge i_sys_clk);
      rd2(addr(11'h490, k), 1'b1, d1, d2);
      check("defects set", d1, 8'hFC);
      check("defects reread", d2, 8'h54);
      lif[k] <= 1'b0;
      lods[k] <= 1'b0;
      rdi[k] <= 1'b0;
      @(posedge i_sys_clk);
      rdc(addr(11'h490, k), 8'hA8);
      rdc(addr(11'h490, k) + 11'h001, 8'h00);
    end
  endtask : t_defects

  task automatic t_phy();
    phy[0] <= 1'b1;
    @(posedge i_sys_clk);
    rdc(11'h490, 8'h02);
    phy[0] <= 1'b0;
    @(posedge i_sys_clk);
    rdc(11'h490, 8'h00);
    wr(11'h490, 8'hFF);
    rdc(11'h490, 8'h02);
    wr(11'h490, 8'h00);
    rdc(11'h490, 8'h00);
    wr(11'h498, 8'hFF);
    rdc(11'h498, 8'h00);
    wr(11'h4A0, 8'hFF);
    rdc(11'h4A0, 8'h00);
  endtask : t_phy

  task automatic t_far_end();
    int l;
    for (int i = 0; i < 8; i++) begin
      l = i * 4 + i % 4;
      u_far.send({5'(l), 2'(i), 1'(i / 4), 5'(i * 2 + 1), 3'(i), 3'(7 - i), 2'(i)});
      rdc(addr(11'h498, l), {2'(i), 1'(i / 4), 5'(i * 2 + 1)});
      rdc(addr(11'h4A0, l), {3'(i), 3'(7 - i), 2'(i)});
    end
    u_far.send({5'h00, 2'h3, 1'b1, 5'h0F, 3'h7, 3'h6, 2'h3});
    rdc(11'h4A0, 8'hFB);
    rdc(11'h498, 8'hEF);
  endtask : t_far_end

  // a held pin must be flagged once, then cleared by the read
  task automatic t_ref();
    ref_hold[16] <= 1'b1;
    repeat (140) @(posedge i_sys_clk);
    rdc(11'h690, 8'h01);
    rdc(11'h690, 8'h00);
    rdc(11'h691, 8'h00);
    ref_hold[16] <= 1'b0;
  endtask : t_ref

  task automatic t_irq();
    wr(11'h7F9, 8'h00);
    wr(11'h7F8, 8'hFF);
    rdc(11'h7F8, 8'h00);
    lif[3] <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    check("irq masked", {7'h00, o_irq}, 8'h00);
    rdc(11'h7F8, 8'h01);
    wr(11'h7F9, 8'h01);
    repeat (2) @(posedge i_sys_clk);
    check("irq raised", {7'h00, o_irq}, 8'h01);
    lif[3] <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    wr(11'h7F8, 8'h01);
    repeat (2) @(posedge i_sys_clk);
    check("irq cleared", {7'h00, o_irq}, 8'h00);
    rdc(11'h000, 8'h00);
    rdc(11'h4FF, 8'h00);
  endtask : t_irq

  task automatic summarize();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // main sequence after 8 reset cycles
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    rdc(11'h797, 8'h00);
    t_defects();
    t_phy();
    t_far_end();
    t_ref();
    t_irq();
    summarize();
  end

  // tests need under a thousand cycles; generous margin
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    errors++;
    summarize();
  end
endmodule : tb

`default_nettype wire

// ---- imr_pkg.sv ----
/*
  imr_pkg: constants, field positions, address map and register kinds for
  the receive link defect and far-end status register bank.
  Assumes an 11-bit byte address space and 8-bit register data.
*/
`default_nettype none

package imr_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int unsigned NUM_LINKS = 32;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 8;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS = 8000;
  // reference input counts as bad after this long with no transition
  localparam int unsigned REF_TIMEOUT_NS = 1000;
  localparam int unsigned REF_TIMEOUT_CYC = (REF_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned REF_CNT_W = 8;
  localparam logic [7:0] REF_CNT_LIM = 8'(REF_TIMEOUT_CYC);

  // ****************************************************************
  // address map: groups of eight links at 0x400 + n*0x100
  // ****************************************************************
  localparam logic [10:0] DEFECT_BASE = 11'h490;
  localparam logic [10:0] FE_CFG_BASE = 11'h498;
  localparam logic [10:0] FE_STATE_BASE = 11'h4A0;
  localparam logic [10:0] GROUP_STRIDE = 11'h100;
  localparam logic [4:0] SLOT_DEFECT = DEFECT_BASE[7:3];
  localparam logic [4:0] SLOT_FE_CFG = FE_CFG_BASE[7:3];
  localparam logic [4:0] SLOT_FE_STATE = FE_STATE_BASE[7:3];
  localparam logic [10:0] IRQ_STATUS_ADDR = 11'h7F8;
  localparam logic [10:0] IRQ_MASK_ADDR = 11'h7F9;

  // ****************************************************************
  // defects register bit positions
  // ****************************************************************
  localparam int unsigned BIT_LIF_CHG = 7;
  localparam int unsigned BIT_LIF = 6;
  localparam int unsigned BIT_LODS_CHG = 5;
  localparam int unsigned BIT_LODS = 4;
  localparam int unsigned BIT_RDI_CHG = 3;
  localparam int unsigned BIT_RDI = 2;
  localparam int unsigned BIT_PHY = 1;
  localparam int unsigned BIT_REF_ERR = 0;

  // ****************************************************************
  // far-end field positions (lsb of each field)
  // ****************************************************************
  localparam int unsigned FL_LSB = 6;
  localparam int unsigned VER_LSB = 5;
  localparam int unsigned LID_LSB = 0;
  localparam int unsigned FE_TX_LSB = 5;
  localparam int unsigned FE_RX_LSB = 2;
  localparam int unsigned FE_DEF_LSB = 0;

  // ****************************************************************
  // interrupt status bit positions and reset values
  // ****************************************************************
  localparam int unsigned IRQ_LIF = 0;
  localparam int unsigned IRQ_LODS = 1;
  localparam int unsigned IRQ_RDI = 2;
  localparam int unsigned IRQ_REF = 3;
  localparam int unsigned IRQ_FE = 4;
  localparam int unsigned IRQ_W = 5;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [31:0] RST_LINKS = 32'h0000_0000;
  localparam logic [4:0] RST_IRQ = 5'h00;
  localparam logic [7:0] RST_REF_CNT = 8'h00;
  localparam logic RST_IRQ_PIN = 1'b0;

  // register kinds selected by an address
  typedef enum logic [2:0] {
    IMR_REG_NONE,
    IMR_REG_DEFECT,
    IMR_REG_FE_CFG,
    IMR_REG_FE_STATE,
    IMR_REG_IRQ_STAT,
    IMR_REG_IRQ_MASK
  } imr_reg_e;

endpackage : imr_pkg

`default_nettype wire
